/* rtl/calib_readout_pkg.sv */
// Package for the calibration readout and DLL mode block.
// Assumes a single 100 MHz clock; commands arrive already sampled.
package calib_readout_pkg;
   // Mode register select codes on the bank address pins
   localparam logic [2:0] MODE_SEL_ZERO = 3'h0;
   localparam logic [2:0] MODE_SEL_ONE = 3'h1;
   localparam logic [2:0] MODE_SEL_THREE = 3'h3;
   // Address bit positions
   localparam int DLL_DIS_BIT = 0;
   localparam int PATTERN_EN_BIT = 2;
   localparam int CHOP_OTF_BIT = 1;
   localparam int CHOP_SEL_BIT = 12;
   localparam int NIBBLE_BIT = 2;
   localparam int DLL_RESET_BIT = 8;
   localparam int CL_LSB = 4;
   // Pattern of location zero, beat 0 in bit 0
   localparam logic [7:0] PATTERN_LOC0 = 8'hAA;
   localparam logic [1:0] LOC_ZERO = 2'h0;
   // Latency used by the block, cycles
   localparam logic [4:0] AL_CYC = 5'h00;
   localparam logic [4:0] DLL_OFF_CL = 5'h06;
   localparam logic [4:0] RESET_CL = 5'h06;
   localparam logic [3:0] BEATS_FULL = 4'h8;
   localparam logic [3:0] BEATS_CHOP = 4'h4;
   // Reset values
   localparam logic RESET_DLL_OFF = 1'b0;
   localparam logic RESET_PATTERN_EN = 1'b0;

   // Sampled command bus
   typedef struct packed {
      logic cs_b;
      logic ras_b;
      logic cas_b;
      logic we_b;
      logic [2:0] bank;
      logic [13:0] addr;
   } cmd_bus_t;

   // Data pins toward the controller
   typedef struct packed {
      logic [7:0] upper_byte_lane;
      logic [7:0] lower_byte_lane;
      logic strobe;
      logic drive;
   } dq_out_t;

   // Decoded command kinds
   typedef enum logic [3:0] {
      CMD_NONE = 4'h1,
      CMD_READ = 4'h2,
      CMD_MODE = 4'h4,
      CMD_OTHER = 4'h8
   } cmd_kind_t;
endpackage : calib_readout_pkg

/* rtl/calib_readout.sv */
// Calibration pattern readout, NOP/deselect decode and DLL-off tracking.
// Assumes commands are synchronous to clk_i and controller obeys sequencing.
// Functional notes
// R1: Mode register three bit 2 set turns pattern readout on; reads redirect.
// R2: Only reads while pattern mode on; autoprecharge part is ignored.
// R3: Pattern bit on lane bit 0; bits 7..1 copy it here.
// R4: Controller keeps column bits 1..0 at zero.
// R5: Full burst needs column bit 2 zero; beats return 0 to 7.
// R6: Chopped burst returns beats 0-3 or 4-7 by column bit 2.
// R7: Bank, column 9..3, autoprecharge and bit 11 are ignored.
// R8: With on-the-fly chop enabled, bit 12 picks chopped or full burst.
// R9: Pattern reads use ordinary read latency and timing.
// R10: Controller issues pattern reads only with DLL locked; the bench also reads with DLL off and right after a DLL reset.
// R11: Beat 0 carries pattern LSB, beat 7 carries MSB.
// R12: Location zero gives 0,1,0,1...; other locations reserved.
// R13: NOP registers no command; running bursts continue.
// R14: Deselect ignores inputs; running bursts continue.
// R15: Mode register one bit 0 set disables DLL until cleared.
// R16: DLL-off supports read and write latency six.
// R17: DLL-off read strobe launches at AL+CL-1 cycles.
// R18: Controller may run any clock up to DLL-off maximum.
// R19: Controller follows DLL-off entry sequence through self refresh.
// R20: Controller holds CKE high, ODT low until tMOD after exit.
// R21: Controller waits tXS, reprograms, waits tMOD.
// R22: Controller follows DLL-on entry sequence through self refresh.
// R23: Controller holds CKE high, ODT low until tDLLK.
// R24: Clear DLL disable, wait tMRD, set DLL reset, wait tMRD.
// R25: Controller waits tDLLK before DLL-dependent commands.
// R26: Internal DLL-enabled state selects strobe launch timing.
`timescale 1ns/1ps
module calib_readout (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire calib_readout_pkg::cmd_bus_t cmd_i,
   output logic [7:0] lower_byte_lane_o,
   output logic [7:0] upper_byte_lane_o,
   output logic dq_oe_o,
   output logic strobe_o,
   output logic pattern_en_o,
   output logic dll_off_o,
   output logic dll_reset_o,
   output logic array_read_o
);
   import calib_readout_pkg::*;

   logic pattern_en_reg;
   logic [1:0] loc_reg;
   logic dll_off_reg;
   logic chop_otf_reg;
   logic [4:0] cl_reg;
   logic dll_reset_reg;
   logic array_read_reg;
   cmd_kind_t kind;
   logic [4:0] wait_reg;
   logic wait_act_reg;
   logic chop_pend_reg;
   logic half_pend_reg;
   logic [3:0] beat_reg;
   logic [3:0] beats_left_reg;
   dq_out_t dq_reg;
   logic [7:0] pattern_sel;

   // Command decode; chip select high or NOP yields no command
   function automatic cmd_kind_t decode(input cmd_bus_t c);
      cmd_kind_t k;
      k = CMD_OTHER;
      // R14: deselect ignored
      if (c.cs_b)
      begin
         k = CMD_NONE;
      end
      // R13: NOP decode
      else if (c.ras_b && c.cas_b && c.we_b)
      begin
         k = CMD_NONE;
      end
      // R2: autoprecharge read decodes as plain read
      else if (c.ras_b && !c.cas_b && c.we_b)
      begin
         k = CMD_READ;
      end
      else if (!c.ras_b && !c.cas_b && !c.we_b)
      begin
         k = CMD_MODE;
      end
      return k;
   endfunction : decode

   assign kind = decode(cmd_i);

   // Mode register shadow bits
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pattern_en_reg <= RESET_PATTERN_EN;
         loc_reg <= LOC_ZERO;
         dll_off_reg <= RESET_DLL_OFF;
         chop_otf_reg <= 1'b0;
         cl_reg <= RESET_CL;
         dll_reset_reg <= 1'b0;
      end
      else
      begin
         dll_reset_reg <= 1'b0;
         if (kind == CMD_MODE)
         begin
            unique case (cmd_i.bank)
               // R1: pattern mode enable
               MODE_SEL_THREE:
               begin
                  pattern_en_reg <= cmd_i.addr[PATTERN_EN_BIT];
                  loc_reg <= cmd_i.addr[1:0];
               end
               // R15: DLL disable bit
               MODE_SEL_ONE:
               begin
                  dll_off_reg <= cmd_i.addr[DLL_DIS_BIT];
               end
               // R24: DLL reset start
               MODE_SEL_ZERO:
               begin
                  chop_otf_reg <= cmd_i.addr[CHOP_OTF_BIT];
                  cl_reg <= {1'b0, cmd_i.addr[CL_LSB +: 3]} + 5'h04;
                  dll_reset_reg <= cmd_i.addr[DLL_RESET_BIT];
               end
               default:
               begin
               end
            endcase
         end
      end
   end

   // R16: DLL-off latency forced to six
   // R17: launch one cycle early when DLL off; R26: state selects
   function automatic logic [4:0] read_delay(input logic off, input logic [4:0] cl);
      logic [4:0] d;
      d = off ? (AL_CYC + DLL_OFF_CL - 5'h01) : (AL_CYC + cl);
      return d - 5'h01;
   endfunction : read_delay

   // Read latency countdown, run for pattern reads only; array reads just pulse array_read_o
   // One countdown only: a read inside the wait is dropped, not queued
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wait_reg <= 5'h00;
         wait_act_reg <= 1'b0;
         chop_pend_reg <= 1'b0;
         half_pend_reg <= 1'b0;
         array_read_reg <= 1'b0;
      end
      else
      begin
         array_read_reg <= 1'b0;
         // R9: same latency as array reads
         if (kind == CMD_READ && !wait_act_reg)
         begin
            wait_reg <= read_delay(dll_off_reg, cl_reg);
            wait_act_reg <= pattern_en_reg;
            array_read_reg <= !pattern_en_reg;
            // R8: on-the-fly chop select; R7: other bits ignored
            chop_pend_reg <= chop_otf_reg && !cmd_i.addr[CHOP_SEL_BIT];
            half_pend_reg <= cmd_i.addr[NIBBLE_BIT];
         end
         else if (wait_act_reg)
         begin
            if (wait_reg == 5'h00)
            begin
               wait_act_reg <= 1'b0;
            end
            else
            begin
               wait_reg <= wait_reg - 5'h01;
            end
         end
      end
   end

   // R12: location zero pattern, reserved locations read zero
   assign pattern_sel = (loc_reg == LOC_ZERO) ? PATTERN_LOC0 : 8'h00;

   // Burst shifter; R13/R14 keep it running through NOP and deselect; a new burst start restarts it
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         beat_reg <= 4'h0;
         beats_left_reg <= 4'h0;
         dq_reg <= '0;
      end
      else if (wait_act_reg && wait_reg == 5'h00)
      begin
         // R5: full burst from beat 0; R6: chop picks nibble
         beat_reg <= (chop_pend_reg && half_pend_reg) ? 4'h5 : 4'h1;
         beats_left_reg <= (chop_pend_reg ? BEATS_CHOP : BEATS_FULL) - 4'h1;
         // R3: bit copied onto all lane bits; R11: LSB first
         dq_reg.lower_byte_lane <= {8{pattern_sel[(chop_pend_reg && half_pend_reg) ? 4 : 0]}};
         dq_reg.upper_byte_lane <= {8{pattern_sel[(chop_pend_reg && half_pend_reg) ? 4 : 0]}};
         dq_reg.strobe <= 1'b1;
         dq_reg.drive <= 1'b1;
      end
      else if (beats_left_reg != 4'h0)
      begin
         beat_reg <= beat_reg + 4'h1;
         beats_left_reg <= beats_left_reg - 4'h1;
         dq_reg.lower_byte_lane <= {8{pattern_sel[beat_reg[2:0]]}};
         dq_reg.upper_byte_lane <= {8{pattern_sel[beat_reg[2:0]]}};
         dq_reg.strobe <= !dq_reg.strobe;
         dq_reg.drive <= 1'b1;
      end
      else
      begin
         dq_reg <= '0;
      end
   end

   // Outputs straight from flip-flops
   assign lower_byte_lane_o = dq_reg.lower_byte_lane;
   assign upper_byte_lane_o = dq_reg.upper_byte_lane;
   assign dq_oe_o = dq_reg.drive;
   assign strobe_o = dq_reg.strobe;
   assign pattern_en_o = pattern_en_reg;
   assign dll_off_o = dll_off_reg;
   assign dll_reset_o = dll_reset_reg;
   assign array_read_o = array_read_reg;

   // Assertions
   sequence s_pat_read;
      kind == CMD_READ && pattern_en_reg && !wait_act_reg && !dll_off_reg
         && cl_reg == 5'h06 && !chop_otf_reg && loc_reg == LOC_ZERO;
   endsequence

   chk_pattern_latency: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R9
      s_pat_read |-> ##7 dq_oe_o && lower_byte_lane_o == 8'h00)
      else $error("pattern burst not at read latency");
   chk_dll_off_early: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R17
      kind == CMD_READ && pattern_en_reg && !wait_act_reg && dll_off_reg
         |-> ##6 dq_oe_o)
      else $error("dll off launch not one cycle early");
   chk_beat_order: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R11
      s_pat_read |-> ##8 lower_byte_lane_o == 8'hFF)
      else $error("beat 1 not pattern bit 1");
   chk_full_length: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R5
      s_pat_read |-> ##7 dq_oe_o [*8] ##1 !dq_oe_o)
      else $error("full burst not eight beats");
   chk_lane_copy: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3
      dq_oe_o |-> lower_byte_lane_o == upper_byte_lane_o)
      else $error("byte lanes differ");
   chk_pattern_on: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R1
      kind == CMD_MODE && cmd_i.bank == MODE_SEL_THREE |=> pattern_en_o == $past(cmd_i.addr[2]))
      else $error("pattern enable not taken");
   chk_dll_bit: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R15
      kind == CMD_MODE && cmd_i.bank == MODE_SEL_ONE |=> dll_off_o == $past(cmd_i.addr[0]))
      else $error("dll disable not taken");
   chk_no_array: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R1
      kind == CMD_READ && pattern_en_reg |=> !array_read_o)
      else $error("pattern read reached array");
   chk_deselect_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R14
      cmd_i.cs_b && !wait_act_reg && beats_left_reg == 4'h0 |=> !wait_act_reg)
      else $error("deselect started a burst");

   // R6 R8: chopped pattern read with DLL on and latency six
   sequence s_chop_read;
      kind == CMD_READ && pattern_en_reg && !wait_act_reg && !dll_off_reg
         && cl_reg == 5'h06 && chop_otf_reg && !cmd_i.addr[CHOP_SEL_BIT]
         && loc_reg == LOC_ZERO;
   endsequence

   // Burst of four beats, then the data pins go quiet
   sequence s_four_beats;
      dq_oe_o [*4] ##1 !dq_oe_o;
   endsequence

   // R13: NOP while the latency count runs
   sequence s_nop_wait;
      kind == CMD_NONE && !cmd_i.cs_b && wait_act_reg && wait_reg != 5'h00;
   endsequence

   // Chopped bursts, reserved locations, array pulses and mode writes
   chk_chop_length: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R8
      s_chop_read |-> ##7 s_four_beats)
      else $error("chopped burst not four beats");
   chk_chop_upper: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R6
      s_chop_read ##0 cmd_i.addr[NIBBLE_BIT] |-> ##7 lower_byte_lane_o == {8{PATTERN_LOC0[4]}}
         ##1 lower_byte_lane_o == {8{PATTERN_LOC0[5]}})
      else $error("upper nibble not from beat four");
   chk_reserved_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R12
      dq_oe_o && loc_reg != LOC_ZERO
         |-> lower_byte_lane_o == 8'h00 && upper_byte_lane_o == 8'h00)
      else $error("reserved location not zero");
   chk_array_pulse: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R1
      kind == CMD_READ && !pattern_en_reg && !wait_act_reg |=> array_read_o)
      else $error("array read not issued");
   chk_dll_reset_pulse: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R24
      kind == CMD_MODE && cmd_i.bank == MODE_SEL_ZERO && cmd_i.addr[DLL_RESET_BIT]
         |=> dll_reset_o ##1 !dll_reset_o)
      else $error("dll reset not a single pulse");
   chk_nop_running: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R13
      s_nop_wait |=> wait_act_reg && wait_reg == $past(wait_reg) - 5'h01)
      else $error("nop disturbed a running read");
endmodule : calib_readout

/* bench/ctrl_model.sv */
// Controller model: drives the sampled command bus of the readout block.
// Assumes the caller orders commands; the bus idles deselected with junk.
`timescale 1ns/1ps
module ctrl_model (
   input wire logic clk_i,
   output calib_readout_pkg::cmd_bus_t cmd_o
);
   import calib_readout_pkg::*;
   logic [31:0] seed = 32'h83A31DD7;

   initial cmd_o = '1;

   // Xorshift source, fixed seed so runs repeat
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic idle(input int n);
      logic [31:0] r;
      repeat (n)
      begin
         @(posedge clk_i);
         r = rnd();
         cmd_o <= {1'b1, r[19:0]};
      end
   endtask : idle

   task automatic send(input logic [3:0] ctl, input logic [2:0] ba, input logic [13:0] a);
      @(posedge clk_i);
      cmd_o <= {ctl, ba, a};
      idle(1);
   endtask : send

   // low column zero, ignored bits random
   task automatic read_pat(input logic full, input logic hi);
      logic [31:0] r;
      r = rnd();
      send(4'b0101, r[2:0], {1'b0, full, r[11:3], hi, 2'b00});
   endtask : read_pat
endmodule : ctrl_model

/* bench/tb_top.sv */
// Testbench for the calibration readout block: scoreboard of beats and pulses.
// Assumes the controller model drives commands; the design asserts its own rules.
`timescale 1ns/1ps
module tb_top;
   import calib_readout_pkg::*;
   typedef struct {int cyc; logic [19:0] val;} exp_t;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   cmd_bus_t cmd;
   logic [7:0] lo, up;
   logic oe, stb, pen, doff, drst, ard;
   logic [19:0] want;
   exp_t exp_q[$];
   int cyc = 0;
   int error_cnt = 0;
   int check_count = 0;
   int t;
   // Lock wait after a DLL reset; plain default count
   localparam int DLLK_WAIT = 512;

   // one steady clock, below any DLL-off ceiling
   always #5 clk_i = ~clk_i;

   ctrl_model ctrl (.clk_i(clk_i), .cmd_o(cmd));
   calib_readout dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_i(cmd),
      .lower_byte_lane_o(lo), .upper_byte_lane_o(up), .dq_oe_o(oe), .strobe_o(stb),
      .pattern_en_o(pen), .dll_off_o(doff), .dll_reset_o(drst), .array_read_o(ard));

   task automatic check(input logic [19:0] s, input logic [19:0] e);
      check_count++;
      if (s !== e)
      begin
         error_cnt++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report

   // notes per beat; NOP mid-wait must not disturb
   task automatic pat_read(input int lat, input int n, input logic full, input logic hi,
                           input logic loc0);
      ctrl.read_pat(full, hi);
      t = cyc;
      for (int b = 0; b < n; b++)
         exp_q.push_back('{t + lat + b, {1'b1, ~b[0], 2'b00,
                           {16{loc0 & PATTERN_LOC0[b + 4 * hi]}}}});
      ctrl.send(4'b0111, 3'h0, 14'h0000);
      ctrl.idle(lat + n);
   endtask : pat_read

   // mode write, spaced past the mode-to-mode wait
   task automatic mode(input logic [2:0] sel, input logic [13:0] a);
      ctrl.send(4'b0000, sel, a);
      t = cyc;
      if (sel == MODE_SEL_ZERO && a[DLL_RESET_BIT])
         exp_q.push_back('{t, 20'h10000});
      ctrl.idle(3);
   endtask : mode

   // Scoreboard: each settled cycle against the oldest due note, else idle
   always @(negedge clk_i)
   begin
      want = 20'h00000;
      if (exp_q.size() > 0 && exp_q[0].cyc == cyc)
      begin
         want = exp_q[0].val;
         void'(exp_q.pop_front());
      end
      if (rst_b_i)
         check({oe, stb, ard, drst, up, lo}, want);
      cyc++;
   end

   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      ctrl.idle(2);
      check(pen, RESET_PATTERN_EN);
      check(doff, RESET_DLL_OFF);
      ctrl.read_pat(1'b1, 1'b0);
      exp_q.push_back('{cyc, 20'h20000});
      ctrl.idle(12);
      mode(MODE_SEL_THREE, 14'h0004);
      check(pen, 1'b1);
      // bit 12 low but no on-the-fly chop: full bursts
      repeat (3) pat_read(6, 8, 1'b0, 1'b0, 1'b1);
      mode(MODE_SEL_ZERO, 14'h0122);
      pat_read(6, 4, 1'b0, 1'b0, 1'b1);
      pat_read(6, 4, 1'b0, 1'b1, 1'b1);
      pat_read(6, 8, 1'b1, 1'b0, 1'b1);
      // DLL off launches one cycle early
      // disable then tMOD spacing; self refresh lies outside
      mode(MODE_SEL_ONE, 14'h0001);
      check(doff, 1'b1);
      pat_read(5, 4, 1'b0, 1'b1, 1'b1);
      mode(MODE_SEL_ONE, 14'h0000);
      mode(MODE_SEL_ZERO, 14'h0120);
      check(doff, 1'b0);
      // no pattern read before the lock wait
      ctrl.idle(DLLK_WAIT);
      pat_read(6, 8, 1'b0, 1'b0, 1'b1);
      mode(MODE_SEL_THREE, 14'h0005);
      pat_read(6, 8, 1'b0, 1'b0, 1'b0);
      mode(MODE_SEL_THREE, 14'h0000);
      check(pen, 1'b0);
      ctrl.read_pat(1'b1, 1'b0);
      exp_q.push_back('{cyc, 20'h20000});
      ctrl.idle(12);
      check(20'(exp_q.size()), 20'h00000);
      final_report();
   end

   // Watchdog: the sequence needs well under a thousand cycles
   initial
   begin
      repeat (3000) @(posedge clk_i);
      error_cnt++;
      final_report();
   end
endmodule : tb_top
